// ==== verilog/reset_seq_pkg.sv ====
// Package: constants for the reset sequencer
package reset_seq_pkg;
    localparam int          NUM_SOURCES    = 8;
    localparam int          SRC_POWER_ON   = 0;
    localparam int          SRC_PIN        = 1;
    localparam int          SRC_COMPARATOR = 2;
    localparam int          SRC_SOFTWARE   = 3;
    localparam int          SRC_SUPPLY     = 4;
    localparam int          SRC_WATCHDOG   = 5;
    localparam int          SRC_MISS_CLK   = 6;
    localparam int          SRC_FLASH_ERR  = 7;
    localparam int          ADDR_W         = 16;
    localparam logic [7:0]  BOOT_MARKER    = 8'hA5;
    localparam logic [15:0] RESET_VECTOR   = 16'h0000;
    localparam logic [15:0] BOOT_VECTOR_DEF = 16'h3A00;
    localparam logic [15:0] SIG_ADDR_DEF   = 16'h3BFE;
    localparam logic [7:0]  PORT_LATCH_RST = 8'hFF;
    localparam logic [1:0]  CLK_SEL_INTERNAL = 2'h0;
    typedef enum logic [1:0] {ST_RESET, ST_FETCH_SIG, ST_WAIT_SIG, ST_RUN} seq_state_t;
endpackage

// ==== verilog/reset_entry_exit_boot_vector.sv ====
// Reset sequencer: gathers reset sources, holds the chip in reset, picks the start vector
`timescale 1ns/1ps
// Notes on behaviour
// - While reset is in force the core is halted and cannot execute.
// - During reset every module register returns to default, except power-on-only bits which keep their value on other resets.
// - While in reset all port pins are forced to a fixed known state.
// - Entering reset disables all interrupts and timers.
// - Reset never touches RAM contents.
// - Reset sets every port output latch to one with open-drain drivers.
// - Weak pull-ups are on during reset and after its release.
// - Power-on and supply-monitor resets drive the reset pin low until reset is left.
// - On leaving reset the program counter is loaded with the start vector and an internal oscillator is chosen.
// - On leaving reset the watchdog is enabled and, without a bootloader, fetch starts at zero.
// - Reset is entered on any of eight sources.
// - The flash byte before the lock byte is read; only the marker value means a bootloader is present.
// - With a bootloader present every reset starts at the bootloader vector.
// - Without a bootloader every reset starts at address zero.
// - A watchdog reset leaves the reset pin undriven.
module reset_entry_exit_boot_vector
    import reset_seq_pkg::*;
#(
    parameter logic [15:0] BOOT_VECTOR = reset_seq_pkg::BOOT_VECTOR_DEF,
    parameter logic [15:0] SIG_ADDR    = reset_seq_pkg::SIG_ADDR_DEF,
    parameter int          PORT_W      = 8
) (
    input  wire logic                                core_clk,
    input  wire logic                                reset,
    input  wire logic [reset_seq_pkg::NUM_SOURCES-1:0] source_req,
    input  wire logic                                reset_pin_n_in,
    input  wire logic [7:0]                          flash_rdata,
    input  wire logic                                flash_rvalid,
    output logic                                     flash_rd_reg,
    output logic [reset_seq_pkg::ADDR_W-1:0]         flash_addr_reg,
    output logic                                     reset_pin_n_out_reg,
    output logic                                     reset_pin_n_oe_reg,
    output logic                                     core_halt_reg,
    output logic                                     module_reset_reg,
    output logic                                     por_reset_reg,
    output logic                                     pc_load_reg,
    output logic [reset_seq_pkg::ADDR_W-1:0]         pc_start_reg,
    output logic [1:0]                               clk_sel_reg,
    output logic                                     watchdog_timer_enable_reg,
    output logic                                     irq_disable_reg,
    output logic                                     timer_disable_reg,
    output logic                                     ram_write_block_reg,
    output logic [PORT_W-1:0]                        port_latch_reg,
    output logic                                     port_open_drain_reg,
    output logic                                     port_pullup_en_reg,
    output logic                                     boot_present_reg,
    output logic [reset_seq_pkg::NUM_SOURCES-1:0]    reset_cause_reg
);
    import reset_seq_pkg::*;

    logic [NUM_SOURCES-1:0] src_meta_reg;
    logic [NUM_SOURCES-1:0] src_sync_reg;
    logic                   any_src;
    logic                   drive_pin;
    seq_state_t             state_reg;
    logic                   exit_now;
    logic                   pin_hold_reg;

    // Chip stays halted and quiet until the sequencer reaches the run state
    function automatic logic hold_state(input logic src, input seq_state_t st);
        return src || st != ST_RUN;
    endfunction

    function automatic logic marker_seen(input logic [7:0] sig);
        return sig == BOOT_MARKER;
    endfunction

    // Two-stage synchroniser; only the second stage is used by logic
    always_ff @(posedge core_clk) begin
        if (reset) begin
            src_meta_reg <= '1;
            src_sync_reg <= '1;
        end else begin
            src_meta_reg <= source_req | {{(NUM_SOURCES-1){1'b0}}, 1'b0};
            src_sync_reg <= src_meta_reg;
        end
    end

    assign any_src   = |src_sync_reg;
    assign drive_pin = src_sync_reg[SRC_POWER_ON] | src_sync_reg[SRC_SUPPLY];
    // Exit happens on the cycle the signature byte arrives with no source active
    assign exit_now  = !any_src && state_reg == ST_WAIT_SIG && flash_rvalid;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_RESET;
        // Any active source restarts the sequence
        end else if (any_src) begin
            state_reg <= ST_RESET;
        end else begin
            case (state_reg)
                ST_RESET:     state_reg <= ST_FETCH_SIG;
                ST_FETCH_SIG: state_reg <= ST_WAIT_SIG;
                ST_WAIT_SIG:  if (flash_rvalid) state_reg <= ST_RUN;
                default:      state_reg <= ST_RUN;
            endcase
        end
    end

    // Signature read from flash
    always_ff @(posedge core_clk) begin
        if (reset) begin
            flash_rd_reg   <= 1'b0;
            flash_addr_reg <= RESET_VECTOR;
        end else begin
            flash_rd_reg   <= !any_src && state_reg == ST_RESET;
            flash_addr_reg <= SIG_ADDR;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            boot_present_reg <= 1'b0;
            pc_start_reg     <= RESET_VECTOR;
            pc_load_reg      <= 1'b0;
        end else begin
            pc_load_reg <= 1'b0;
            if (exit_now) begin
                boot_present_reg <= marker_seen(flash_rdata);
                pc_start_reg     <= marker_seen(flash_rdata) ? BOOT_VECTOR
                                                             : RESET_VECTOR;
                pc_load_reg      <= 1'b1;
            end
        end
    end

    // Reset-state controls, held until the start vector is loaded; module reset is held only until ST_RESET is left
    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_halt_reg       <= 1'b1;
            module_reset_reg    <= 1'b1;
            irq_disable_reg     <= 1'b1;
            timer_disable_reg   <= 1'b1;
            ram_write_block_reg <= 1'b1;
        end else begin
            core_halt_reg       <= hold_state(any_src, state_reg);
            module_reset_reg    <= any_src || state_reg == ST_RESET;
            irq_disable_reg     <= hold_state(any_src, state_reg);
            timer_disable_reg   <= hold_state(any_src, state_reg);
            ram_write_block_reg <= hold_state(any_src, state_reg);
        end
    end

    // Power-on-only domain reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            por_reset_reg <= 1'b1;
        end else begin
            por_reset_reg <= src_sync_reg[SRC_POWER_ON];
        end
    end

    // Port pin state
    always_ff @(posedge core_clk) begin
        if (reset) begin
            port_latch_reg      <= {PORT_W{1'b1}};
            port_open_drain_reg <= 1'b1;
            port_pullup_en_reg  <= 1'b1;
        end else begin
            if (any_src || state_reg == ST_RESET) begin
                port_latch_reg      <= {PORT_W{1'b1}};
                port_open_drain_reg <= 1'b1;
            end
            port_pullup_en_reg <= 1'b1;
        end
    end

    // Pin stays driven from a power-on or supply reset until the start vector is loaded
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pin_hold_reg <= 1'b1;
        end else if (drive_pin) begin
            pin_hold_reg <= 1'b1;
        end else if (any_src || exit_now) begin
            // Any other source, watchdog included, releases the pin
            pin_hold_reg <= 1'b0;
        end
    end

    // Reset pin is only ever pulled low; the pull-up gives the high level
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reset_pin_n_out_reg <= 1'b0;
            reset_pin_n_oe_reg  <= 1'b1;
        end else begin
            reset_pin_n_out_reg <= 1'b0;
            reset_pin_n_oe_reg  <= drive_pin || pin_hold_reg;
        end
    end

    // Clock source falls back to the internal oscillator in reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            clk_sel_reg <= CLK_SEL_INTERNAL;
        end else if (any_src) begin
            clk_sel_reg <= CLK_SEL_INTERNAL;
        end
    end

    // Watchdog off while in reset, switched on at exit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            watchdog_timer_enable_reg <= 1'b0;
        end else if (any_src) begin
            watchdog_timer_enable_reg <= 1'b0;
        end else if (exit_now) begin
            watchdog_timer_enable_reg <= 1'b1;
        end
    end

    // Latest reset cause, kept after exit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reset_cause_reg <= '0;
        end else if (any_src) begin
            reset_cause_reg <= src_sync_reg;
        end
    end
endmodule // reset_entry_exit_boot_vector

// ==== bench/flash_model.sv ====
// Flash model that answers the signature read
`timescale 1ns/1ps
module flash_model (
    input  wire logic       core_clk,
    input  wire logic       flash_rd_reg,
    input  wire logic [7:0] sig_value,
    input  wire logic [1:0] delay,
    output logic      [7:0] flash_rdata,
    output logic            flash_rvalid
);
    logic [2:0] cnt = 3'h0;
    logic [7:0] noise = 8'h5A;
    always_ff @(posedge core_clk) cnt <= flash_rd_reg ? 3'h1 + delay : cnt - 3'(cnt != 3'h0);
    always_ff @(posedge core_clk) noise <= ~noise;
    assign flash_rvalid = cnt == 3'h1;
    // Bus toggles outside the valid cycle
    assign flash_rdata = flash_rvalid ? sig_value : noise;
endmodule // flash_model

// ==== bench/reset_seq_asserts.sv ====
// Port assertions for the reset sequencer
`timescale 1ns/1ps
module reset_seq_asserts import reset_seq_pkg::*;
#(parameter logic [15:0] BOOT_VECTOR = BOOT_VECTOR_DEF, SIG_ADDR = SIG_ADDR_DEF, parameter int PORT_W = 8) (
    input wire logic core_clk, reset, flash_rd_reg, reset_pin_n_out_reg, reset_pin_n_oe_reg, core_halt_reg,
    input wire logic module_reset_reg, pc_load_reg, watchdog_timer_enable_reg, irq_disable_reg, boot_present_reg,
    input wire logic port_open_drain_reg, port_pullup_en_reg,
    input wire logic [7:0] source_req,
    input wire logic [15:0] flash_addr_reg, pc_start_reg,
    input wire logic [1:0] clk_sel_reg,
    input wire logic [PORT_W-1:0] port_latch_reg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    hold_in_reset_a: assert property (
        (|source_req) [*4] |-> core_halt_reg && module_reset_reg && irq_disable_reg) else $error("not held");
    port_state_a: assert property (
        module_reset_reg [*2] |-> &port_latch_reg && port_open_drain_reg) else $error("port state");
    pullup_on_a: assert property (port_pullup_en_reg) else $error("pullups off");
    pin_drive_a: assert property (
        (source_req[0] || source_req[4]) [*4] |-> reset_pin_n_oe_reg && !reset_pin_n_out_reg) else $error("pin");
    watchdog_pin_a: assert property ((source_req == 8'h20) [*5] |-> !reset_pin_n_oe_reg) else $error("pin");
    start_vector_a: assert property (
        pc_load_reg |-> pc_start_reg == (boot_present_reg ? BOOT_VECTOR : RESET_VECTOR)) else $error("vector");
    exit_setup_a: assert property (
        pc_load_reg |-> clk_sel_reg == CLK_SEL_INTERNAL && watchdog_timer_enable_reg ##1 !core_halt_reg) else $error("exit");
    sig_read_a: assert property (flash_rd_reg |-> flash_addr_reg == SIG_ADDR) else $error("sig addr");
    cover property (pc_load_reg && boot_present_reg);
    cover property (pc_load_reg && !boot_present_reg);
    cover property ((source_req == 8'h20) [*5]);
endmodule // reset_seq_asserts
bind reset_entry_exit_boot_vector reset_seq_asserts #(.BOOT_VECTOR(BOOT_VECTOR), .SIG_ADDR(SIG_ADDR), .PORT_W(PORT_W))
    u_asserts (.*);

// ==== bench/reset_entry_exit_boot_vector_test.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module reset_entry_exit_boot_vector_test;
    import reset_seq_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1;
    logic [7:0] source_req = 8'hFF, sig_value = BOOT_MARKER;
    int n_tests = 0, n_fail = 0;
    wire [15:0] flash_addr_reg, pc_start_reg;
    wire [7:0] flash_rdata, port_latch_reg, reset_cause_reg;
    wire [1:0] clk_sel_reg;
    wire flash_rvalid, flash_rd_reg, reset_pin_n_out_reg, reset_pin_n_oe_reg, core_halt_reg, module_reset_reg;
    wire por_reset_reg, pc_load_reg, watchdog_timer_enable_reg, irq_disable_reg, timer_disable_reg, boot_present_reg;
    wire ram_write_block_reg, port_open_drain_reg, port_pullup_en_reg;
    wire reset_pin_n_in = reset_pin_n_oe_reg ? reset_pin_n_out_reg : 1'b1;
    always #50 core_clk = ~core_clk;
    reset_entry_exit_boot_vector DUT (.*);
    flash_model u_flash (.*, .delay(sig_value[1:0]));
    task automatic check(input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) n_fail++;
        if (seen !== exp) $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    endtask
    task automatic conclude();
        $display("%0d compares, %0d wrong", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic boot_run(input logic [7:0] sig, input logic pin_low);
        int i;
        logic [19:0] exp_exit;
        @(posedge core_clk);
        {sig_value, source_req} <= {sig, 8'h00};
        for (i = 0; i < 40 && pc_load_reg !== 1'b1; i++) @(negedge core_clk);
        if (i == 40) n_fail++;
        if (i == 40) conclude();
        exp_exit = {sig == BOOT_MARKER, 1'b1, CLK_SEL_INTERNAL, sig == BOOT_MARKER ? BOOT_VECTOR_DEF : RESET_VECTOR};
        check({boot_present_reg, watchdog_timer_enable_reg, clk_sel_reg, pc_start_reg}, exp_exit);
        check(reset_pin_n_in, !pin_low);
        @(negedge core_clk);
        check({core_halt_reg, irq_disable_reg, timer_disable_reg, ram_write_block_reg, module_reset_reg}, 5'h00);
        check({por_reset_reg, reset_pin_n_in}, 2'h1);
        $display("start-up with signature %h done", sig);
    endtask
    task automatic source_hold(input int n);
        logic [24:0] seen_hold;
        logic [24:0] exp_hold;
        @(posedge core_clk);
        source_req <= 8'h01 << n;
        repeat (6) @(negedge core_clk);
        seen_hold = {core_halt_reg, module_reset_reg, irq_disable_reg, timer_disable_reg, ram_write_block_reg,
                     port_open_drain_reg, port_pullup_en_reg, por_reset_reg, reset_pin_n_in, port_latch_reg,
                     reset_cause_reg};
        exp_hold = {7'h7F, n == SRC_POWER_ON, !(n == SRC_POWER_ON || n == SRC_SUPPLY), PORT_LATCH_RST, 8'h01 << n};
        check(seen_hold, exp_hold);
        $display("hold of source %0d done", n);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        boot_run(BOOT_MARKER, 1'b1);
        for (int n = 0; n < NUM_SOURCES; n++) begin
            source_hold(n);
            boot_run(8'hA4 ^ 8'(n), n == SRC_POWER_ON || n == SRC_SUPPLY);
        end
        conclude();
    end
endmodule // reset_entry_exit_boot_vector_test
